// File: design/dca_pkg.sv
// shared constants, command codes and helpers for the memory link
package dca_pkg;
    localparam int DQ_W = 8;
    localparam int BEATS = 8;
    localparam int CHOP_BEATS = 4;
    localparam int WORD_W = DQ_W * BEATS;
    localparam int BANK_W = 3;
    localparam int ROW_W = 16;
    localparam int COL_W = 10;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam logic BC_CHOP_VAL = 1'b0;
    // burst mode field, low bits of the mode command address
    localparam logic [1:0] MR_BL8 = 2'h0;
    localparam logic [1:0] MR_OTF = 2'h1;
    localparam logic [1:0] MR_BC4 = 2'h2;
    // timing
    localparam int CLK_NS = 25;
    localparam int CK_PERIOD_NS = 400;
    localparam int CK_HALF = CK_PERIOD_NS / (2 * CLK_NS);
    localparam int DQS_DLY = 2;
    localparam int INIT_NS = 8000;
    localparam int INIT_CK_DEF = INIT_NS / CK_PERIOD_NS;
    localparam int REF_NS = 7800;
    localparam int REF_CK_DEF = REF_NS / CK_PERIOD_NS;
    localparam int CMD_GAP_CK = 2;
    localparam int REF_GAP_CK = 4;
    // controller register map (word index)
    localparam int RA_W = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_ROW = 3'h1;
    localparam logic [2:0] REG_COL = 3'h2;
    localparam logic [2:0] REG_WD_LO = 3'h3;
    localparam logic [2:0] REG_WD_HI = 3'h4;
    localparam logic [2:0] REG_RD_LO = 3'h5;
    localparam logic [2:0] REG_RD_HI = 3'h6;
    localparam logic [2:0] REG_STAT = 3'h7;
    localparam int CTRL_GO = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_AP = 2;
    localparam int CTRL_CHOP = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int ROW_BANK_LSB = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_INIT = 1;
    localparam int STAT_RDV = 2;

    // {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        CMD_MRS = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR = 3'b100,
        CMD_RD = 3'b101,
        CMD_NOP = 3'b111
    } dca_cmd_t;

    // sequential wrap inside the 8-beat word
    function automatic logic [2:0] beat_pos(input logic [2:0] start,
                                            input logic [3:0] i);
        return start + i[2:0];
    endfunction

    function automatic logic [3:0] burst_len(input logic [1:0] mode,
                                             input logic a12);
        if (mode == MR_BC4)
            return 4'(CHOP_BEATS);
        if (mode == MR_OTF && a12 == BC_CHOP_VAL)
            return 4'(CHOP_BEATS);
        return 4'(BEATS);
    endfunction
endpackage

// File: design/dca_if.sv
// link between controller and memory, with two-way pin resolution
`timescale 1ns/1ps
interface dca_if;
    import dca_pkg::*;
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] a;
    logic [DQ_W-1:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic ctl_dqs_o;
    logic ctl_dqs_n_o;
    logic ctl_dqs_oe;
    logic [DQ_W-1:0] mem_dq_o;
    logic mem_dq_oe;
    logic mem_dqs_o;
    logic mem_dqs_n_o;
    logic mem_dqs_oe;
    logic [DQ_W-1:0] dq;
    logic dqs;
    logic dqs_n;

    // undriven data and strobe read low, the strobe complement reads high
    assign dq = mem_dq_oe ? mem_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
    assign dqs = mem_dqs_oe ? mem_dqs_o : (ctl_dqs_oe & ctl_dqs_o);
    assign dqs_n = mem_dqs_oe ? mem_dqs_n_o :
                   (ctl_dqs_oe ? ctl_dqs_n_o : 1'b1);

    modport ctl (
        output ck, cs_n, ras_n, cas_n, we_n, ba, a,
        output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_n_o, ctl_dqs_oe,
        input dq, dqs, dqs_n
    );
    modport mem (
        input ck, cs_n, ras_n, cas_n, we_n, ba, a,
        output mem_dq_o, mem_dq_oe, mem_dqs_o, mem_dqs_n_o, mem_dqs_oe,
        input dq, dqs, dqs_n
    );
endinterface

// File: design/dca_sync.sv
// three-flop pin synchroniser with settled level and edge pulses
`timescale 1ns/1ps
module dca_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin side
    input wire logic din,
    // settled level and edges
    output logic lvl,
    output logic rise,
    output logic fall
);
    logic [2:0] s_ff;
    logic lvl_ff;
    logic agree;

    assign agree = s_ff[1] == s_ff[2];
    assign lvl = lvl_ff;
    assign rise = agree & s_ff[2] & ~lvl_ff;
    assign fall = agree & ~s_ff[2] & lvl_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= 3'h0;
            lvl_ff <= 1'b0;
        end else begin
            s_ff <= {s_ff[1:0], din};
            if (agree)
                lvl_ff <= s_ff[2];
        end
    end
endmodule

// File: design/dca_mem.sv
// memory end: eight banks, command capture, prefetch word, strobed data
`timescale 1ns/1ps
module dca_mem #(
    parameter int ROW_AW = 1,
    parameter int CWA = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    dca_if.mem link,
    // status
    output logic init_done,
    output logic [7:0] bank_open,
    output logic cmd_err,
    output logic ref_seen
);
    import dca_pkg::*;
    localparam int IDX_W = BANK_W + ROW_AW + CWA;
    localparam int DEPTH = 1 << IDX_W;

    logic ck_rise, ck_fall, dqs_rise, dqs_fall, ck_ev, dqs_ev;
    logic [WORD_W-1:0] mem_ff [DEPTH];
    logic [ROW_W-1:0] row_ff [8];
    logic [7:0] open_ff;
    logic init_ff, err_ff, ref_ff;
    logic [1:0] mode_ff;
    logic act_ff, bwr_ff, bap_ff;
    logic [BANK_W-1:0] bbank_ff;
    logic [IDX_W-1:0] bidx_ff;
    logic [2:0] col3_ff;
    logic [3:0] nb_ff, bcnt_ff;
    logic [WORD_W-1:0] word_ff, wr_word;
    logic [DQ_W-1:0] dq_ff;
    logic dq_oe_ff, dqs_ff;
    logic [1:0] dly_ff;
    logic sel, bank_is_open, is_mrs, is_act, is_rw, is_pre, is_ref;
    logic rw_ok, bad, rd_beat, rd_end, wr_beat, wr_end;
    logic [IDX_W-1:0] cmd_idx;
    logic [ROW_W-1:0] cur_row;
    dca_cmd_t cmd;

    dca_sync u_ck (.clk(clk), .rst_n(rst_n), .din(link.ck), .lvl(),
                   .rise(ck_rise), .fall(ck_fall));
    dca_sync u_dqs (.clk(clk), .rst_n(rst_n), .din(link.dqs), .lvl(),
                    .rise(dqs_rise), .fall(dqs_fall));

    assign ck_ev = ck_rise | ck_fall;
    assign dqs_ev = dqs_rise | dqs_fall;
    // commands are taken on the rising edge of the link clock
    assign sel = ck_rise & ~link.cs_n;
    assign cmd = dca_cmd_t'({link.ras_n, link.cas_n, link.we_n});
    assign bank_is_open = open_ff[link.ba];
    assign cur_row = row_ff[link.ba];
    assign cmd_idx = {link.ba, cur_row[ROW_AW-1:0], link.a[CWA+2:3]};
    assign is_mrs = sel & (cmd == CMD_MRS);
    assign is_act = sel & (cmd == CMD_ACT) & init_ff & ~bank_is_open;
    assign is_rw = sel & ((cmd == CMD_RD) | (cmd == CMD_WR));
    assign rw_ok = is_rw & init_ff & bank_is_open & ~act_ff;
    assign is_pre = sel & (cmd == CMD_PRE) & init_ff;
    assign is_ref = sel & (cmd == CMD_REF) & init_ff & ~|open_ff;
    // anything else that is not a no-op is refused and flagged
    assign bad = sel & (cmd != CMD_NOP) & ~is_mrs & ~is_act & ~rw_ok
                 & ~is_pre & ~is_ref;
    assign rd_beat = act_ff & ~bwr_ff & ck_ev & (bcnt_ff != nb_ff);
    assign rd_end = act_ff & ~bwr_ff & ck_ev & (bcnt_ff == nb_ff);
    assign wr_beat = act_ff & bwr_ff & dqs_ev;
    assign wr_end = wr_beat & (bcnt_ff == nb_ff - 4'h1);

    always_comb begin
        wr_word = word_ff;
        wr_word[beat_pos(col3_ff, bcnt_ff) * DQ_W +: DQ_W] = link.dq;
    end

    assign init_done = init_ff;
    assign bank_open = open_ff;
    assign cmd_err = err_ff;
    assign ref_seen = ref_ff;
    assign link.mem_dq_o = dq_ff;
    assign link.mem_dq_oe = dq_oe_ff;
    assign link.mem_dqs_o = dqs_ff;
    assign link.mem_dqs_n_o = ~dqs_ff;
    assign link.mem_dqs_oe = dq_oe_ff;

    // one core write of the whole word
    always_ff @(posedge clk) begin
        if (wr_end)
            mem_ff[bidx_ff] <= wr_word;
        if (is_act)
            row_ff[link.ba] <= link.a;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_ff <= 1'b0;
            mode_ff <= MR_BL8;
            open_ff <= 8'h00;
            err_ff <= 1'b0;
            ref_ff <= 1'b0;
        end else begin
            err_ff <= bad;
            ref_ff <= is_ref;
            if (is_mrs) begin
                init_ff <= 1'b1;
                mode_ff <= link.a[1:0];
            end
            if ((rd_end | wr_end) & bap_ff)
                open_ff[bbank_ff] <= 1'b0;
            if (is_act)
                open_ff[link.ba] <= 1'b1;
            if (is_pre & link.a[AP_BIT])
                open_ff <= 8'h00;
            else if (is_pre)
                open_ff[link.ba] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_ff <= 1'b0;
            bwr_ff <= 1'b0;
            bap_ff <= 1'b0;
            bbank_ff <= '0;
            bidx_ff <= '0;
            col3_ff <= 3'h0;
            nb_ff <= 4'h0;
            bcnt_ff <= 4'h0;
            word_ff <= '0;
        end else if (rw_ok) begin
            act_ff <= 1'b1;
            bwr_ff <= cmd == CMD_WR;
            bap_ff <= link.a[AP_BIT];
            bbank_ff <= link.ba;
            bidx_ff <= cmd_idx;
            col3_ff <= link.a[2:0];
            nb_ff <= burst_len(mode_ff, link.a[BC_BIT]);
            bcnt_ff <= 4'h0;
            word_ff <= mem_ff[cmd_idx];
        end else if (rd_beat | wr_beat) begin
            bcnt_ff <= bcnt_ff + 4'h1;
            if (wr_beat)
                word_ff <= wr_word;
            if (wr_end)
                act_ff <= 1'b0;
        end else if (rd_end) begin
            act_ff <= 1'b0;
        end
    end

    // read beats leave on each link clock edge, strobe toggles two clocks after each data beat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_ff <= '0;
            dq_oe_ff <= 1'b0;
            dqs_ff <= 1'b0;
            dly_ff <= 2'h0;
        end else begin
            if (rd_beat) begin
                dq_ff <= word_ff[beat_pos(col3_ff, bcnt_ff) * DQ_W +: DQ_W];
                dq_oe_ff <= 1'b1;
                dly_ff <= 2'(DQS_DLY);
            end else if (dly_ff != 2'h0) begin
                dly_ff <= dly_ff - 2'h1;
            end
            if (dly_ff == 2'h1)
                dqs_ff <= ~dqs_ff;
            if (rd_end)
                dq_oe_ff <= 1'b0;
        end
    end
endmodule

// File: design/dca_ctl.sv
// controller end: init, refresh, activate then access, strobed data
`timescale 1ns/1ps
// Notes on behaviour
// - memory holds eight independent banks
// - activate a bank before read or write
// - activate carries bank bits and row
// - read or write carries starting column
// - A10 with access selects auto precharge
// - A12 picks chop four or eight
// - one core word, eight pin beats
// - data and differential strobe are two-way
// - reads and writes share address lines
// - controller runs init before normal traffic
// - controller refreshes the memory periodically
module dca_ctl #(
    parameter int INIT_CK = dca_pkg::INIT_CK_DEF,
    parameter int REF_CK = dca_pkg::REF_CK_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [dca_pkg::RA_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // memory link
    dca_if.ctl link
);
    import dca_pkg::*;
    typedef enum logic [1:0] {
        S_INIT = 2'b00,
        S_IDLE = 2'b01,
        S_ACT = 2'b10,
        S_XFER = 2'b11
    } dca_st_t;
    dca_st_t st_ff, nxt_st;
    dca_cmd_t cmd_ff, nxt_cmd;
    logic [BANK_W-1:0] ba_ff, nxt_ba, bank_ff;
    logic [ROW_W-1:0] a_ff, nxt_a, row_ff;
    logic [7:0] gap_ff, nxt_gap, ref_cnt_ff;
    logic ck_ff, tog, fall, take_go, take_ref, take_x, start_x, wend, rend;
    logic go_ff, wr_ff, ap_ff, chop_ff, rdv_ff, ref_due_ff, xdone_ff;
    logic [1:0] mode_ff, mr_ff, dly_ff;
    logic [COL_W-1:0] col_ff;
    logic [WORD_W-1:0] wd_ff, rd_ff;
    logic [31:0] rmux, rdata_ff;
    logic busy, cfg_wr, w_ctrl, w_row, w_col, w_lo, w_hi, a12, wbeat;
    logic [3:0] div_ff, nb_ff, bcnt_ff, rcnt_ff;
    logic [2:0] col3_ff;
    logic [DQ_W-1:0] dq_ff;
    logic wact_ff, skip_ff, ract_ff, dqs_ff, dqs_rise, dqs_fall, dqs_ev;
    dca_sync u_dqs (.clk(clk), .rst_n(rst_n), .din(link.dqs), .lvl(),
                    .rise(dqs_rise), .fall(dqs_fall));
    // link clock by division of the system clock
    assign tog = div_ff == 4'(CK_HALF - 1);
    assign fall = tog & ck_ff;
    assign dqs_ev = dqs_rise | dqs_fall;
    // register decode; setup is frozen while an access runs
    assign busy = go_ff | (st_ff == S_ACT) | (st_ff == S_XFER);
    assign cfg_wr = reg_wr & ~busy;
    assign w_ctrl = cfg_wr & (reg_addr == REG_CTRL);
    assign w_row = cfg_wr & (reg_addr == REG_ROW);
    assign w_col = cfg_wr & (reg_addr == REG_COL);
    assign w_lo = cfg_wr & (reg_addr == REG_WD_LO);
    assign w_hi = cfg_wr & (reg_addr == REG_WD_HI);
    assign a12 = chop_ff ? BC_CHOP_VAL : ~BC_CHOP_VAL;
    always_comb begin
        case (reg_addr)
            REG_CTRL: rmux = {26'h0, mode_ff, chop_ff, ap_ff, wr_ff, go_ff};
            REG_ROW: rmux = {13'h0, bank_ff, row_ff};
            REG_COL: rmux = {22'h0, col_ff};
            REG_WD_LO: rmux = wd_ff[31:0];
            REG_WD_HI: rmux = wd_ff[63:32];
            REG_RD_LO: rmux = rd_ff[31:0];
            REG_RD_HI: rmux = rd_ff[63:32];
            REG_STAT: rmux = {29'h0, rdv_ff, st_ff != S_INIT, busy};
            default: rmux = 32'h0;
        endcase
    end
    assign reg_rdata = rdata_ff;
    // command sequencer steps on falling link clock edges
    always_comb begin
        nxt_st = st_ff;
        nxt_gap = gap_ff;
        nxt_cmd = cmd_ff;
        nxt_ba = ba_ff;
        nxt_a = a_ff;
        take_go = 1'b0;
        take_ref = 1'b0;
        take_x = 1'b0;
        start_x = 1'b0;
        if (fall) begin
            nxt_cmd = CMD_NOP;
            if (gap_ff != 8'h0) begin
                nxt_gap = gap_ff - 8'h1;
            end else begin
                case (st_ff)
                    S_INIT: begin
                        nxt_cmd = CMD_MRS;
                        nxt_a = {14'h0, mode_ff};
                        nxt_st = S_IDLE;
                        nxt_gap = 8'(CMD_GAP_CK);
                    end
                    S_IDLE: begin
                        if (ref_due_ff) begin
                            nxt_cmd = CMD_REF;
                            take_ref = 1'b1;
                            nxt_gap = 8'(REF_GAP_CK);
                        end else if (go_ff) begin
                            nxt_cmd = CMD_ACT;
                            nxt_ba = bank_ff;
                            nxt_a = row_ff;
                            take_go = 1'b1;
                            nxt_st = S_ACT;
                            nxt_gap = 8'(CMD_GAP_CK);
                        end
                    end
                    S_ACT: begin
                        nxt_cmd = wr_ff ? CMD_WR : CMD_RD;
                        nxt_a = 16'(col_ff);
                        nxt_a[AP_BIT] = ap_ff;
                        nxt_a[BC_BIT] = a12;
                        start_x = 1'b1;
                        nxt_st = S_XFER;
                    end
                    S_XFER: begin
                        if (xdone_ff) begin
                            take_x = 1'b1;
                            nxt_st = S_IDLE;
                            nxt_gap = 8'(CMD_GAP_CK);
                            if (!ap_ff) begin
                                nxt_cmd = CMD_PRE;
                                nxt_a = 16'h0000;
                            end
                        end
                    end
                    default: nxt_st = S_INIT;
                endcase
            end
        end
    end
    assign link.ck = ck_ff;
    assign link.cs_n = cmd_ff == CMD_NOP;
    assign {link.ras_n, link.cas_n, link.we_n} = cmd_ff;
    assign link.ba = ba_ff;
    assign link.a = a_ff;
    assign link.ctl_dq_o = dq_ff;
    assign link.ctl_dq_oe = wact_ff;
    assign link.ctl_dqs_o = dqs_ff;
    assign link.ctl_dqs_n_o = ~dqs_ff;
    assign link.ctl_dqs_oe = wact_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 4'h0;
            ck_ff <= 1'b0;
            st_ff <= S_INIT;
            gap_ff <= 8'(INIT_CK);
            cmd_ff <= CMD_NOP;
            ba_ff <= '0;
            a_ff <= '0;
            mr_ff <= MR_BL8;
            ref_cnt_ff <= 8'h0;
            ref_due_ff <= 1'b0;
            xdone_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            div_ff <= tog ? 4'h0 : div_ff + 4'h1;
            ck_ff <= ck_ff ^ tog;
            st_ff <= nxt_st;
            gap_ff <= nxt_gap;
            cmd_ff <= nxt_cmd;
            ba_ff <= nxt_ba;
            a_ff <= nxt_a;
            if (st_ff == S_INIT && nxt_st == S_IDLE)
                mr_ff <= mode_ff;
            if (fall)
                ref_cnt_ff <= (ref_cnt_ff == 8'(REF_CK - 1)) ? 8'h0
                              : ref_cnt_ff + 8'h1;
            // a new refresh demand wins over the one being served
            ref_due_ff <= (fall & (ref_cnt_ff == 8'(REF_CK - 1)))
                          | (ref_due_ff & ~take_ref);
            xdone_ff <= wend | rend | (xdone_ff & ~take_x);
            rdata_ff <= reg_rd ? rmux : 32'h0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            go_ff <= 1'b0;
            wr_ff <= 1'b0;
            ap_ff <= 1'b0;
            chop_ff <= 1'b0;
            mode_ff <= MR_BL8;
            bank_ff <= '0;
            row_ff <= '0;
            col_ff <= '0;
            wd_ff <= '0;
            rdv_ff <= 1'b0;
        end else begin
            go_ff <= (w_ctrl & reg_wdata[CTRL_GO]) | (go_ff & ~take_go);
            if (w_ctrl) begin
                wr_ff <= reg_wdata[CTRL_WR];
                ap_ff <= reg_wdata[CTRL_AP];
                chop_ff <= reg_wdata[CTRL_CHOP];
                mode_ff <= reg_wdata[CTRL_MODE_LSB +: 2];
            end
            if (w_row) begin
                bank_ff <= reg_wdata[ROW_BANK_LSB +: BANK_W];
                row_ff <= reg_wdata[ROW_W-1:0];
            end
            if (w_col)
                col_ff <= reg_wdata[COL_W-1:0];
            if (w_lo)
                wd_ff[31:0] <= reg_wdata;
            if (w_hi)
                wd_ff[63:32] <= reg_wdata;
            rdv_ff <= rend | (rdv_ff & ~(w_ctrl & reg_wdata[CTRL_GO]));
        end
    end
    // write beats on link clock edges after the command edge
    assign wbeat = wact_ff & tog & ~skip_ff & (bcnt_ff != nb_ff);
    assign wend = wact_ff & tog & ~skip_ff & (bcnt_ff == nb_ff);
    assign rend = ract_ff & dqs_ev & (rcnt_ff == nb_ff - 4'h1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nb_ff <= 4'h0;
            col3_ff <= 3'h0;
            wact_ff <= 1'b0;
            skip_ff <= 1'b0;
            bcnt_ff <= 4'h0;
            ract_ff <= 1'b0;
            rcnt_ff <= 4'h0;
        end else if (start_x) begin
            nb_ff <= burst_len(mr_ff, a12);
            col3_ff <= col_ff[2:0];
            wact_ff <= wr_ff;
            skip_ff <= 1'b1;
            bcnt_ff <= 4'h0;
            ract_ff <= ~wr_ff;
            rcnt_ff <= 4'h0;
        end else begin
            if (wact_ff & tog)
                skip_ff <= 1'b0;
            if (wbeat)
                bcnt_ff <= bcnt_ff + 4'h1;
            if (wend)
                wact_ff <= 1'b0;
            if (ract_ff & dqs_ev)
                rcnt_ff <= rcnt_ff + 4'h1;
            if (rend)
                ract_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_ff <= '0;
            dqs_ff <= 1'b0;
            dly_ff <= 2'h0;
            rd_ff <= '0;
        end else begin
            if (wbeat) begin
                dq_ff <= wd_ff[beat_pos(col3_ff, bcnt_ff) * DQ_W +: DQ_W];
                dly_ff <= 2'(DQS_DLY);
            end else if (dly_ff != 2'h0) begin
                dly_ff <= dly_ff - 2'h1;
            end
            if (dly_ff == 2'h1)
                dqs_ff <= ~dqs_ff;
            if (ract_ff & dqs_ev)
                rd_ff[beat_pos(col3_ff, rcnt_ff) * DQ_W +: DQ_W] <= link.dq;
        end
    end
endmodule

// File: sim/dca_monitor.sv
// link protocol checker between controller and memory ends
`timescale 1ns/1ps
module dca_monitor (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // command pins
    input logic ck,
    input logic cs_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n,
    input logic [dca_pkg::BANK_W-1:0] ba,
    input logic [dca_pkg::ROW_W-1:0] a,
    // data pin drivers
    input logic ctl_dq_oe,
    input logic ctl_dqs_o,
    input logic ctl_dqs_n_o,
    input logic ctl_dqs_oe,
    input logic mem_dq_oe,
    input logic mem_dqs_o,
    input logic mem_dqs_n_o,
    input logic mem_dqs_oe
);
    import dca_pkg::*;
    logic [2:0] cmd;
    logic [2:0] last_ff;
    assign cmd = {ras_n, cas_n, we_n};
    // last command seen with chip select low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            last_ff <= CMD_NOP;
        else if (!cs_n)
            last_ff <= cmd;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ck_high: assert property ($rose(ck) |-> ck[*8] ##1 !ck)
        else $error("link clock high phase wrong");
    a_cmd_ck_low: assert property ($changed(cmd) |-> !ck)
        else $error("command changed while link clock high");
    a_cmd_stable: assert property ($fell(cs_n) |=>
        ($stable({cs_n, cmd, ba, a}))[*8])
        else $error("command or address not held");
    a_act_first: assert property ($fell(cs_n) &&
        (cmd == CMD_RD || cmd == CMD_WR) |-> last_ff == CMD_ACT)
        else $error("access without activate");
    a_init_first: assert property ($fell(cs_n) &&
        last_ff == CMD_NOP |-> cmd == CMD_MRS)
        else $error("first command not mode set");
    a_ref_closed: assert property ($fell(cs_n) &&
        cmd == CMD_REF |-> last_ff != CMD_ACT)
        else $error("refresh with a row open");
    a_wr_burst: assert property ($rose(ctl_dq_oe) |->
        !cs_n && cmd == CMD_WR ##0 ctl_dq_oe[*8])
        else $error("write data not after write command");
    a_rd_source: assert property ($rose(mem_dq_oe) |-> last_ff == CMD_RD)
        else $error("read data not after read command");
    a_one_driver: assert property (!(ctl_dq_oe && mem_dq_oe))
        else $error("both ends drive data");
    a_dqs_pair: assert property ((ctl_dqs_oe |-> ctl_dqs_n_o == !ctl_dqs_o)
        and (mem_dqs_oe |-> mem_dqs_n_o == !mem_dqs_o))
        else $error("strobe pair not complementary");
    c_act: cover property ($fell(cs_n) && cmd == CMD_ACT);
    c_ref: cover property ($fell(cs_n) && cmd == CMD_REF);
    c_wr: cover property ($rose(ctl_dq_oe));
    c_rd: cover property ($rose(mem_dq_oe));
endmodule

// File: sim/ddr3_command_addressing_tb.sv
// self-checking bench joining controller and memory ends
`timescale 1ns/1ps
module ddr3_command_addressing_tb;
    import dca_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, init_done, cmd_err, ref_seen, rd_d;
    logic [RA_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [7:0] bank_open;
    logic [63:0] notes[$];
    logic [63:0] d[8];
    logic [63:0] n, x;
    logic [15:0] row[8];
    int fail_count, checks, cyc, errs, refs;
    dca_if link_if();
    dca_ctl #(.INIT_CK(2), .REF_CK(12)) dca_ctl_i(.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link_if));
    dca_mem dca_mem_i(.clk(clk), .rst_n(rst_n), .link(link_if),
        .init_done(init_done), .bank_open(bank_open), .cmd_err(cmd_err),
        .ref_seen(ref_seen));
    dca_monitor dca_monitor_i(.clk(clk), .rst_n(rst_n), .ck(link_if.ck),
        .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
        .we_n(link_if.we_n), .ba(link_if.ba), .a(link_if.a),
        .ctl_dq_oe(link_if.ctl_dq_oe), .ctl_dqs_o(link_if.ctl_dqs_o),
        .ctl_dqs_n_o(link_if.ctl_dqs_n_o), .ctl_dqs_oe(link_if.ctl_dqs_oe),
        .mem_dq_oe(link_if.mem_dq_oe), .mem_dqs_o(link_if.mem_dqs_o),
        .mem_dqs_n_o(link_if.mem_dqs_n_o), .mem_dqs_oe(link_if.mem_dqs_oe));
    always #12.5 clk = ~clk;
    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(logic [2:0] ad, logic [31:0] dt);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [2:0] ad, logic [31:0] e, logic [31:0] m);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        notes.push_back({m, e});
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask
    // wait until initialised and not busy
    task automatic idle();
        forever begin
            rd(REG_STAT, 32'h0, 32'h0);
            if (v[STAT_BUSY] === 1'b0 && v[STAT_INIT] === 1'b1)
                break;
        end
    endtask
    task automatic go(logic w, logic ap, logic ch, int b, logic [9:0] col);
        wr(REG_ROW, {13'h0, 3'(b), row[b]});
        wr(REG_COL, {22'h0, col});
        wr(REG_CTRL, {26'h0, MR_OTF, ch, ap, w, 1'b1});
        idle();
    endtask
    task automatic ld(logic [63:0] y);
        wr(REG_WD_LO, y[31:0]);
        wr(REG_WD_HI, y[63:32]);
    endtask
    task automatic chk64(logic [63:0] e, logic [63:0] m);
        rd(REG_RD_LO, e[31:0], m[31:0]);
        rd(REG_RD_HI, e[63:32], m[63:32]);
    endtask
    always @(posedge clk) begin
        rd_d <= reg_rd;
        errs <= errs + (cmd_err === 1'b1);
        refs <= refs + (ref_seen === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            test_done();
        end
    end
    always @(negedge clk) begin
        if (rd_d) begin
            n = notes.pop_front();
            check("reg_rdata", reg_rdata & n[63:32], n[31:0] & n[63:32]);
        end
    end
    initial begin
        clk = 0;
        rst_n = 0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 0;
        reg_rd = 0;
        void'($urandom(32'h885C));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wr(REG_CTRL, {26'h0, MR_OTF, 4'h0});
        idle();
        for (int b = 0; b < 8; b++) begin
            d[b] = {$urandom, $urandom};
            row[b] = 16'($urandom);
            ld(d[b]);
            go(1'b1, b[0], 1'b0, b, 10'h0);
        end
        for (int b = 0; b < 8; b++) begin
            go(1'b0, !b[0], 1'b0, b, 10'(b));
            chk64(d[b], '1);
        end
        x = {$urandom, $urandom};
        ld(x);
        go(1'b1, 1'b0, 1'b1, 2, 10'h4);
        go(1'b0, 1'b0, 1'b0, 2, 10'h0);
        chk64({x[63:32], d[2][31:0]}, '1);
        go(1'b0, 1'b1, 1'b0, 3, 10'h0);
        go(1'b0, 1'b1, 1'b1, 2, 10'h6);
        chk64({x[63:48], d[3][47:16], d[2][15:0]}, '1);
        // second reset, fixed chop of four from the mode set
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(REG_CTRL, {26'h0, MR_BC4, 4'h0});
        idle();
        ld(~x);
        go(1'b1, 1'b0, 1'b0, 2, 10'h0);
        go(1'b0, 1'b1, 1'b0, 2, 10'h0);
        chk64({32'h0, ~x[31:0]}, '1);
        rd(REG_STAT, 32'h6, 32'h7);
        check("init_done", init_done, 64'h1);
        check("bank_open", bank_open, 64'h0);
        check("cmd_err", errs, 64'h0);
        check("ref_seen", refs != 0, 64'h1);
        test_done();
    end
endmodule
